// [nid_pkg.sv]
// Package for the node identity and PHY register mailbox block.
// Assumes an APB slave with 32-bit data and byte addresses.
package nid_pkg;
  localparam logic [11:0] NID_OFF_NODE_IDENTITY = 12'h0e8;
  localparam logic [11:0] NID_OFF_PHY_MAILBOX = 12'h0ec;
  localparam logic [11:0] NID_OFF_IRQ_STATUS = 12'h0f8;
  localparam logic [11:0] NID_OFF_IRQ_MASK = 12'h0fc;

  // Node identity fields
  localparam int NID_VALID_BIT = 31;
  localparam int NID_ROOT_BIT = 30;
  localparam int NID_CPS_BIT = 27;
  localparam int NID_BUS_LSB = 6;
  localparam int NID_BUS_W = 10;
  localparam int NID_NODE_W = 6;
  localparam logic [9:0] NID_BUS_RESET = 10'h3ff;
  localparam logic [5:0] NID_NODE_UNASSIGNED = 6'h3f;

  // Mailbox fields
  localparam int MBX_DONE_BIT = 31;
  localparam int MBX_RADDR_LSB = 24;
  localparam int MBX_RDATA_LSB = 16;
  localparam int MBX_RD_BIT = 15;
  localparam int MBX_WR_BIT = 14;
  localparam int MBX_TADDR_LSB = 8;
  localparam int MBX_ADDR_W = 4;
  localparam int MBX_DATA_W = 8;

  // Interrupt bits
  localparam int IRQ_W = 3;
  localparam int IRQ_BUS_RESET = 0;
  localparam int IRQ_NODE_VALID = 1;
  localparam int IRQ_PHY_DONE = 2;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [3:0] addr;
    logic [7:0] data;
  } nid_phy_req_s;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] data;
  } nid_phy_resp_s;
endpackage : nid_pkg

// [nid_sync.sv]
// Two-flop synchroniser for a bundle of pin levels.
// Assumes the inputs are levels from outside the pclk domain.
`timescale 1ns/1ns
module nid_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : nid_sync

// [nid_regs.sv]
// Node identity register and PHY register mailbox, APB slave.
// Assumes the PHY-facing link logic runs on pclk and gives single-cycle
// strobes; the PHY status levels are asynchronous and are synchronised here.
`timescale 1ns/1ns
// Notes on behaviour
// - Node-valid flag clears on bus reset, sets when a new node number arrives.
// - Root flag set during bus reset handling when the PHY reports root.
// - Cable power bit mirrors the PHY cable power report.
// - Unused bits of both registers read as zero.
// - Bridge segment id is software writable, resets to all ones.
// - Node id is segment id above physical node index, 16 bits.
// - Physical node index loaded from PHY after self-id; software cannot write.
// - Completion flag clears when software sets read or write request.
// - Completion flag sets when a register transfer comes back from PHY.
// - Returned index captures address of latest PHY register transfer.
// - Returned value captures PHY register contents; read only.
// - Read request bit sends read to PHY, then hardware clears it.
// - Write request bit sends write to PHY unless read is also set, then hardware clears it.
// - Target index field names the PHY register for the next request.
// - Outgoing value sent on writes, ignored on reads.
module nid_regs
  import nid_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bus_reset_pin,
  input wire logic phy_is_root_pin,
  input wire logic cable_power_ok_pin,
  input wire logic node_index_strobe,
  input wire logic [5:0] node_index_value,
  output nid_phy_req_s phy_req,
  output logic phy_req_valid,
  input wire logic phy_req_ready,
  input wire logic phy_resp_valid,
  input wire nid_phy_resp_s phy_resp,
  output logic [15:0] node_id,
  output logic node_id_valid,
  output logic irq
);
  logic bus_reset_s;
  logic phy_is_root_s;
  logic cable_power_ok_s;
  logic bus_reset_d1_q;
  logic bus_reset_rise;

  nid_sync #(.W(3)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({bus_reset_pin, phy_is_root_pin, cable_power_ok_pin}),
    .q({bus_reset_s, phy_is_root_s, cable_power_ok_s})
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_reset_d1_q <= 1'b0;
    end else begin
      bus_reset_d1_q <= bus_reset_s;
    end
  end

  assign bus_reset_rise = bus_reset_s & ~bus_reset_d1_q;

  // APB decode; every access completes without wait states
  logic wr_en;
  logic rd_en;
  logic hit;

  function automatic logic is_mapped(input logic [11:0] a);
    return (a == NID_OFF_NODE_IDENTITY) || (a == NID_OFF_PHY_MAILBOX) ||
           (a == NID_OFF_IRQ_STATUS) || (a == NID_OFF_IRQ_MASK);
  endfunction : is_mapped

  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : lane_merge

  assign hit = is_mapped(paddr);
  assign wr_en = psel & penable & pwrite & hit;
  assign rd_en = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;

  logic [31:0] wmask;
  assign wmask = lane_merge(32'h0000_0000, 32'hffff_ffff, pstrb);

  // One write strobe per register keeps each address compare in one place
  logic wr_id;
  logic wr_ists;
  logic wr_imask;
  assign wr_id = wr_en && paddr == NID_OFF_NODE_IDENTITY;
  assign wr_ists = wr_en && paddr == NID_OFF_IRQ_STATUS;
  assign wr_imask = wr_en && paddr == NID_OFF_IRQ_MASK;

  // Node identity state
  logic valid_q;
  logic root_q;
  logic cps_q;
  logic [NID_BUS_W-1:0] bus_q;
  logic [NID_NODE_W-1:0] node_q;

  // A new node number in the same cycle as a bus reset edge wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid_q <= 1'b0;
    end else if (node_index_strobe) begin
      valid_q <= 1'b1;
    end else if (bus_reset_rise) begin
      valid_q <= 1'b0;
    end
  end

  // Root is captured while bus reset processing is under way
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      root_q <= 1'b0;
    end else if (bus_reset_s) begin
      root_q <= phy_is_root_s;
    end
  end

  // One flop after the synchroniser, so readback lags the pin by three edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cps_q <= 1'b0;
    end else begin
      cps_q <= cable_power_ok_s;
    end
  end

  logic [31:0] bus_merged;
  assign bus_merged = lane_merge(32'h0000_0000, pwdata, pstrb);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_q <= NID_BUS_RESET;
    end else if (wr_id) begin
      for (int i = 0; i < NID_BUS_W; i++) begin
        if (wmask[NID_BUS_LSB + i]) begin
          bus_q[i] <= bus_merged[NID_BUS_LSB + i];
        end
      end
    end
  end

  // Unassigned until the PHY reports; software writes are ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      node_q <= NID_NODE_UNASSIGNED;
    end else if (node_index_strobe) begin
      node_q <= node_index_value;
    end
  end

  assign node_id = {bus_q, node_q};
  assign node_id_valid = valid_q;

  // Mailbox state
  logic done_q;
  logic rd_req_q;
  logic wr_req_q;
  logic [MBX_ADDR_W-1:0] taddr_q;
  logic [MBX_DATA_W-1:0] wdata_q;
  logic [MBX_ADDR_W-1:0] raddr_q;
  logic [MBX_DATA_W-1:0] rdata_q;
  logic mbx_wr;
  logic set_rd;
  logic set_wr;
  logic sent;

  // A request bit is set only when its byte lane is written with a one
  assign mbx_wr = wr_en && paddr == NID_OFF_PHY_MAILBOX;
  assign set_rd = mbx_wr & wmask[MBX_RD_BIT] & pwdata[MBX_RD_BIT];
  assign set_wr = mbx_wr & wmask[MBX_WR_BIT] & pwdata[MBX_WR_BIT];
  assign sent = phy_req_valid & phy_req_ready;

  // A mailbox write while a request is pending retargets it; further sets while pending are merged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_req_q <= 1'b0;
      wr_req_q <= 1'b0;
    end else if (sent) begin
      // A set written in the sending cycle starts the next request, not lost
      rd_req_q <= set_rd;
      wr_req_q <= set_wr;
    end else begin
      if (set_rd) begin
        rd_req_q <= 1'b1;
      end
      if (set_wr) begin
        wr_req_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      taddr_q <= '0;
      wdata_q <= '0;
    end else if (mbx_wr) begin
      for (int i = 0; i < MBX_ADDR_W; i++) begin
        if (wmask[MBX_TADDR_LSB + i]) begin
          taddr_q[i] <= pwdata[MBX_TADDR_LSB + i];
        end
      end
      for (int i = 0; i < MBX_DATA_W; i++) begin
        if (wmask[i]) begin
          wdata_q[i] <= pwdata[i];
        end
      end
    end
  end

  // The PHY answer sets the flag over a same-cycle software request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 1'b0;
    end else if (phy_resp_valid) begin
      done_q <= 1'b1;
    end else if (set_rd || set_wr) begin
      done_q <= 1'b0;
    end
  end

  // Address and data land on the same edge as the flag, never after it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raddr_q <= '0;
      rdata_q <= '0;
    end else if (phy_resp_valid) begin
      raddr_q <= phy_resp.addr;
      rdata_q <= phy_resp.data;
    end
  end

  // Read requests carry zero data so the outgoing value has no effect
  assign phy_req_valid = rd_req_q | wr_req_q;
  always_comb begin
    phy_req = '0;
    phy_req.rd = rd_req_q;
    phy_req.wr = wr_req_q & ~rd_req_q;
    phy_req.addr = taddr_q;
    phy_req.data = rd_req_q ? '0 : wdata_q;
  end

  // Interrupts
  logic [IRQ_W-1:0] ists_q;
  logic [IRQ_W-1:0] imask_q;
  logic [IRQ_W-1:0] ievt;
  logic [IRQ_W-1:0] iclr;

  always_comb begin
    ievt = '0;
    ievt[IRQ_BUS_RESET] = bus_reset_rise;
    ievt[IRQ_NODE_VALID] = node_index_strobe;
    ievt[IRQ_PHY_DONE] = phy_resp_valid;
  end

  assign iclr = wr_ists ?
                (pwdata[IRQ_W-1:0] & wmask[IRQ_W-1:0]) : '0;

  // Set wins over a same-cycle clear so no event is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ists_q <= '0;
    end else begin
      ists_q <= (ists_q & ~iclr) | ievt;
    end
  end

  logic [31:0] imask_merged;
  assign imask_merged = lane_merge({{(32 - IRQ_W){1'b0}}, imask_q}, pwdata, pstrb);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      imask_q <= '0;
    end else if (wr_imask) begin
      imask_q <= imask_merged[IRQ_W-1:0];
    end
  end

  assign irq = |(ists_q & imask_q);

  // Read mux
  logic [31:0] rd_val;

  always_comb begin
    rd_val = '0;
    case (paddr)
      NID_OFF_NODE_IDENTITY: begin
        rd_val[NID_VALID_BIT] = valid_q;
        rd_val[NID_ROOT_BIT] = root_q;
        rd_val[NID_CPS_BIT] = cps_q;
        rd_val[NID_BUS_LSB +: NID_BUS_W] = bus_q;
        rd_val[NID_NODE_W-1:0] = node_q;
      end
      NID_OFF_PHY_MAILBOX: begin
        rd_val[MBX_DONE_BIT] = done_q;
        rd_val[MBX_RADDR_LSB +: MBX_ADDR_W] = raddr_q;
        rd_val[MBX_RDATA_LSB +: MBX_DATA_W] = rdata_q;
        rd_val[MBX_RD_BIT] = rd_req_q;
        rd_val[MBX_WR_BIT] = wr_req_q;
        rd_val[MBX_TADDR_LSB +: MBX_ADDR_W] = taddr_q;
        rd_val[MBX_DATA_W-1:0] = wdata_q;
      end
      NID_OFF_IRQ_STATUS: rd_val[IRQ_W-1:0] = ists_q;
      NID_OFF_IRQ_MASK: rd_val[IRQ_W-1:0] = imask_q;
      default: rd_val = '0;
    endcase
  end

  // Read data held in a flop, loaded in the setup cycle so it is valid at access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_val;
    end else if (rd_en) begin
      prdata <= rd_val;
    end
  end
endmodule : nid_regs

// [nid_regs_props.sv]
// Port-level checker for the node identity and PHY mailbox block.
// Assumes one pclk domain with asynchronous active-low reset.
`timescale 1ns/1ns
module nid_props
  import nid_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic bus_reset_pin,
  input wire logic node_index_strobe,
  input wire logic [5:0] node_index_value,
  input wire nid_phy_req_s phy_req,
  input wire logic phy_req_valid,
  input wire logic phy_req_ready,
  input wire logic phy_resp_valid,
  input wire nid_phy_resp_s phy_resp,
  input wire logic [15:0] node_id,
  input wire logic node_id_valid
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr_acc = psel && penable && pwrite;
  wire rd_set = psel && !penable && !pwrite;
  sequence s_resp_read;
    phy_resp_valid ##1 (rd_set && paddr == NID_OFF_PHY_MAILBOX && !phy_resp_valid);
  endsequence
  sequence s_reset_held;
    $rose(bus_reset_pin) ##1 (bus_reset_pin && !node_index_strobe) [*4];
  endsequence
  a_valid_on_strobe: assert property (
    node_index_strobe |=> node_id_valid && node_id[5:0] == $past(node_index_value))
    else $error("node number not taken");
  a_reset_clears: assert property (s_reset_held |-> !node_id_valid)
    else $error("valid kept over bus reset");
  a_req_taken: assert property (
    phy_req_valid && phy_req_ready && !wr_acc |=> !phy_req_valid)
    else $error("request not cleared");
  a_req_single: assert property (phy_req_valid |-> !(phy_req.rd && phy_req.wr))
    else $error("read and write together");
  a_req_held: assert property (
    phy_req_valid && !phy_req_ready && !wr_acc |=> phy_req_valid && $stable(phy_req))
    else $error("request changed while waiting");
  a_rd_data_zero: assert property (phy_req_valid && phy_req.rd |-> phy_req.data == 8'h00)
    else $error("read carries data");
  a_resp_fields: assert property (
    s_resp_read |=> prdata[31:16] == {4'h8, $past(phy_resp, 2)})
    else $error("reply fields wrong");
  a_id_readback: assert property (
    rd_set && paddr == NID_OFF_NODE_IDENTITY |=> prdata[15:0] == $past(node_id)
      && prdata[31] == $past(node_id_valid) && prdata[29:28] == 2'h0 && prdata[26:16] == 11'h000)
    else $error("node id readback wrong");
  a_mbx_zeros: assert property (
    rd_set && paddr == NID_OFF_PHY_MAILBOX |=> prdata[30:28] == 3'h0 && prdata[13:12] == 2'h0)
    else $error("mailbox reserved bits set");
endmodule : nid_props

bind nid_regs nid_props u_nid_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .prdata, .bus_reset_pin, .node_index_strobe, .node_index_value, .phy_req, .phy_req_valid,
  .phy_req_ready, .phy_resp_valid, .phy_resp, .node_id, .node_id_valid);

// [nid_phy_model.sv]
// Behavioural PHY register port: accepts link requests, answers reads.
// Assumes the link holds a request until it sees ready.
`timescale 1ns/1ns
module nid_phy_model
  import nid_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire nid_phy_req_s phy_req,
  input wire logic phy_req_valid,
  output logic phy_req_ready,
  output logic phy_resp_valid,
  output nid_phy_resp_s phy_resp
);
  logic [7:0] mem [16];
  logic [2:0] cnt;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 3'h0;
      phy_req_ready <= 1'b0;
      phy_resp_valid <= 1'b0;
      phy_resp <= '0;
      for (int i = 0; i < 16; i++) mem[i] <= 8'h00;
    end else begin
      phy_req_ready <= 1'b0;
      phy_resp_valid <= 1'b0;
      // Reply lines invert once in the cycle after an answer so a stale value never looks like an answer
      if (phy_resp_valid) phy_resp <= ~phy_resp;
      if (phy_req_valid && phy_req_ready) begin
        cnt <= 3'h0;
        if (phy_req.wr) mem[phy_req.addr] <= phy_req.data;
        else begin
          phy_resp_valid <= 1'b1;
          phy_resp <= {phy_req.addr, mem[phy_req.addr]};
        end
      end else if (phy_req_valid) begin
        cnt <= cnt + 3'h1;
        phy_req_ready <= (cnt >= (slow ? 3'h5 : 3'h0));
      end
    end
  end
endmodule : nid_phy_model

// [tb_node_id_and_phy_reg_access.sv]
// Self-checking bench for the node identity and PHY mailbox block.
// Assumes a zero-wait APB slave and the behavioural PHY model.
`timescale 1ns/1ns
module tb_node_id_and_phy_reg_access;
  import nid_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic brst = 1'b0, is_root = 1'b0, pwr_ok = 1'b0, strobe = 1'b0, slow = 1'b0;
  logic [5:0] nidx = 6'h00;
  logic pready, pslverr, irq, node_id_valid, phy_req_valid, phy_req_ready, phy_resp_valid, err;
  logic [15:0] node_id;
  nid_phy_req_s phy_req;
  nid_phy_resp_s phy_resp;
  int n_mismatch = 0;
  int checks_done = 0;
  always #2 pclk = ~pclk;
  nid_regs u_nid_regs (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb(4'hf), .prdata, .pready, .pslverr, .bus_reset_pin(brst), .phy_is_root_pin(is_root),
    .cable_power_ok_pin(pwr_ok), .node_index_strobe(strobe), .node_index_value(nidx), .phy_req,
    .phy_req_valid, .phy_req_ready, .phy_resp_valid, .phy_resp, .node_id, .node_id_valid, .irq);
  nid_phy_model u_nid_phy_model (.pclk, .presetn, .slow, .phy_req, .phy_req_valid,
    .phy_req_ready, .phy_resp_valid, .phy_resp);

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Trailing idle edge keeps back-to-back calls from driving psel twice in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        n_mismatch++;
        print_verdict();
      end
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    apb(1'b0, NID_OFF_PHY_MAILBOX, 32'h0);
    while (rd[b] !== v) begin
      n++;
      if (n > 50) begin
        n_mismatch++;
        print_verdict();
      end
      apb(1'b0, NID_OFF_PHY_MAILBOX, 32'h0);
    end
  endtask : poll

  task automatic pulse_reset();
    brst <= 1'b1;
    repeat (6) @(posedge pclk);
    brst <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask : pulse_reset

  task automatic t_reset();
    apb(1'b0, NID_OFF_NODE_IDENTITY, 32'h0);
    chk(rd, 32'h0000ffff);
    apb(1'b0, NID_OFF_PHY_MAILBOX, 32'h0);
    chk(rd, 32'h00000000);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_node();
    pwr_ok <= 1'b1;
    is_root <= 1'b1;
    pulse_reset();
    nidx <= 6'h05;
    strobe <= 1'b1;
    @(posedge pclk);
    strobe <= 1'b0;
    apb(1'b1, NID_OFF_NODE_IDENTITY, 32'hffffffff);
    apb(1'b0, NID_OFF_NODE_IDENTITY, 32'h0);
    chk(rd, 32'hc800ffc5);
    apb(1'b1, NID_OFF_NODE_IDENTITY, 32'h0);
    chk({16'h0, node_id}, 32'h00000005);
    is_root <= 1'b0;
    pwr_ok <= 1'b0;
    pulse_reset();
    apb(1'b0, NID_OFF_NODE_IDENTITY, 32'h0);
    chk(rd, 32'h00000005);
    $display("t_node done");
  endtask : t_node

  task automatic t_irq();
    apb(1'b1, NID_OFF_IRQ_MASK, 32'h00000002);
    chk({31'h0, irq}, 32'h00000001);
    apb(1'b1, NID_OFF_IRQ_STATUS, 32'h00000002);
    chk({31'h0, irq}, 32'h00000000);
    apb(1'b0, NID_OFF_IRQ_STATUS, 32'h0);
    chk(rd, 32'h00000001);
    $display("t_irq done");
  endtask : t_irq

  task automatic t_phy();
    slow <= 1'b1;
    apb(1'b1, NID_OFF_PHY_MAILBOX, 32'h0000435a);
    poll(14, 1'b0);
    slow <= 1'b0;
    apb(1'b1, NID_OFF_PHY_MAILBOX, 32'h00008377);
    poll(31, 1'b1);
    chk(rd, 32'h835a0377);
    apb(1'b0, NID_OFF_IRQ_STATUS, 32'h0);
    chk(rd, 32'h00000005);
    apb(1'b1, NID_OFF_PHY_MAILBOX, 32'h00ff4311);
    poll(14, 1'b0);
    chk(rd, 32'h035a0311);
    $display("t_phy done");
  endtask : t_phy

  task automatic t_err();
    apb(1'b0, 12'h0f0, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    $display("t_err done");
  endtask : t_err

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_node();
    t_irq();
    t_phy();
    t_err();
    print_verdict();
  end
endmodule : tb_node_id_and_phy_reg_access
